// ### dmarb_defines.vh
`ifndef DMARB_DEFINES_VH
`define DMARB_DEFINES_VH

// register offsets
`define DMARB_OFF_CTRL 8'h00
`define DMARB_OFF_CTRLB 8'h04
`define DMARB_OFF_CHPTR 8'h08
`define DMARB_OFF_SHORT 8'h0C
`define DMARB_OFF_RLIVE 8'h10
`define DMARB_OFF_RINIT 8'h14
`define DMARB_OFF_SRC 8'h18
`define DMARB_OFF_DST 8'h1C
`define DMARB_OFF_TCW 8'h20
`define DMARB_OFF_BLIVE 8'h24
`define DMARB_OFF_BINIT 8'h28
`define DMARB_OFF_BCNT 8'h2C
`define DMARB_OFF_STAT 8'h30

// control register fields
`define DMARB_B_EN 0
`define DMARB_B_DONE_IE 1
`define DMARB_B_SIZE 2
`define DMARB_B_SRC_DEC 3
`define DMARB_B_SRC_STEP 4
`define DMARB_B_DST_DEC 5
`define DMARB_B_DST_STEP 6
`define DMARB_B_BURST 7
`define DMARB_B_LEVEL 8
`define DMARB_F_MODE 10:9
`define DMARB_F_SEL 14:12
`define DMARB_B_AREA_SRC 0
`define DMARB_CTRL_W 15

// modes
`define DMARB_MODE_REPEAT 2'h0
`define DMARB_MODE_NORMAL 2'h1
`define DMARB_MODE_BLOCK 2'h2

// activation sources
`define DMARB_SEL_TMR0 3'h0
`define DMARB_SEL_TMR1 3'h1
`define DMARB_SEL_TMR2 3'h2
`define DMARB_SEL_TXE 3'h3
`define DMARB_SEL_RXF 3'h4
`define DMARB_SEL_ADC 3'h5
`define DMARB_SEL_EXT 3'h6
`define DMARB_SEL_AUTO 3'h7

// reset values
`define DMARB_RST_CTRL 15'h0000
`define DMARB_RST_PTR 24'h000000
`define DMARB_RST_B8 8'h00
`define DMARB_RST_B16 16'h0000
`define DMARB_SHORT_HI 16'hFFFF

`endif

// ### dmarb_addr_step.v
`timescale 1ns/10ps
module dmarb_addr_step #(
	parameter AW = 24
)(
	ptr,
	step_en,
	dec,
	size,
	next_ptr
);
	input wire [AW-1:0] ptr;
	input wire step_en;
	input wire dec;
	input wire size;
	output wire [AW-1:0] next_ptr;

	wire [AW-1:0] amount;

	// RQ24: one or two per step
	assign amount = {{(AW-2){1'b0}}, size, !size};
	assign next_ptr = !step_en ? ptr : (dec ? ptr - amount : ptr + amount);
endmodule

// ### dmarb_req_sel.v
`timescale 1ns/10ps
`include "dmarb_defines.vh"
module dmarb_req_sel (
	sys_clk,
	rst,
	enable,
	mode,
	sel,
	level_sense,
	irq_in,
	ext_req_n,
	take,
	hit,
	irq_ack,
	irq_hide
);
	input wire sys_clk;
	input wire rst;
	input wire enable;
	input wire [1:0] mode;
	input wire [2:0] sel;
	input wire level_sense;
	input wire [5:0] irq_in;
	input wire ext_req_n;
	input wire take;
	output wire hit;
	output wire [5:0] irq_ack;
	output wire [5:0] irq_hide;

	reg ext_prev_r;
	reg ext_pend_r;
	reg legal;
	wire ext_fall;
	wire int_sel;
	wire [5:0] sel_vec;

	assign int_sel = sel < `DMARB_SEL_EXT;
	assign sel_vec = int_sel ? (6'h01 << sel) : 6'h00;
	assign ext_fall = ext_prev_r && !ext_req_n;

	// RQ9: RQ13: RQ20: legal sources per mode
	always @*
	begin
		case (mode)
			`DMARB_MODE_REPEAT: legal = sel != `DMARB_SEL_AUTO;
			`DMARB_MODE_NORMAL: legal = !int_sel;
			`DMARB_MODE_BLOCK: legal = sel != `DMARB_SEL_AUTO && sel != `DMARB_SEL_TXE && sel != `DMARB_SEL_RXF;
			default: legal = 1'b0;
		endcase
	end

	// falling edge held until taken
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ext_prev_r <= 1'b1;
			ext_pend_r <= 1'b0;
		end
		else
		begin
			ext_prev_r <= ext_req_n;
			if (ext_fall)
				ext_pend_r <= 1'b1;
			else if (take)
				ext_pend_r <= 1'b0;
		end
	end

	// RQ22: block mode edge only
	assign hit = enable && legal && (
		(int_sel && |(irq_in & sel_vec)) ||
		(sel == `DMARB_SEL_EXT && (ext_pend_r ||
			(level_sense && mode != `DMARB_MODE_BLOCK && !ext_req_n))) ||
		sel == `DMARB_SEL_AUTO);
	// RQ23: clear flag, hide from cpu
	assign irq_ack = (take && enable && legal) ? sel_vec : 6'h00;
	assign irq_hide = (enable && legal) ? sel_vec : 6'h00;
endmodule

// ### dmarb_top.v
// Function
// RQ1: repeat: one unit per request, reload, continue
// RQ2: receive-full copies fixed to pointer, else reverse
// RQ3: live count decrements, reloads from init
// RQ4: pointer restore by signed scaled init count
// RQ5: software loads live and init equal
// RQ6: repeat runs until disabled, no interrupt
// RQ7: fixed address low byte, upper ones
// RQ8: repeat count eight bits, max 255
// RQ9: repeat accepts timer, serial, converter, external
// RQ10: normal pairs 24-bit source and destination
// RQ11: normal count hits zero: disable, interrupt
// RQ12: normal start count zero means 65536
// RQ13: normal external or auto request
// RQ14: cycle-steal releases, burst holds bus
// RQ15: block request moves a whole block
// RQ16: block size reload, area restore, count
// RQ17: block count zero: disable, interrupt
// RQ18: area select bit, zero is destination
// RQ19: software loads block size and count
// RQ20: block accepts timer, converter, external only
// RQ21: block area cycles or stays fixed
// RQ22: block external requests are edges only
// RQ23: taken interrupt flag cleared and hidden
// RQ24: step one for byte, two word
`timescale 1ns/10ps
`include "dmarb_defines.vh"
module dmarb_top (
	sys_clk,
	rst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	irq_in,
	ext_req_n,
	irq_ack,
	irq_hide,
	hp_bus_req,
	xfer_req,
	xfer_src,
	xfer_dst,
	xfer_word,
	xfer_ack,
	bus_hold,
	done_irq
);
	input wire sys_clk;
	input wire rst;
	input wire [7:0] reg_addr;
	input wire [31:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output reg [31:0] reg_rdata;
	input wire [5:0] irq_in;
	input wire ext_req_n;
	output wire [5:0] irq_ack;
	output wire [5:0] irq_hide;
	input wire hp_bus_req;
	output wire xfer_req;
	output reg [23:0] xfer_src;
	output reg [23:0] xfer_dst;
	output wire xfer_word;
	input wire xfer_ack;
	output wire bus_hold;
	output wire done_irq;

	localparam ST_IDLE = 2'h0;
	localparam ST_XFER = 2'h1;
	localparam ST_BLOCK = 2'h2;

	reg [`DMARB_CTRL_W-1:0] ctrl_r;
	reg ctrlb_r;
	reg [23:0] chptr_r;
	reg [7:0] short_r;
	reg [7:0] rlive_r;
	reg [7:0] rinit_r;
	reg [23:0] src_r;
	reg [23:0] dst_r;
	reg [15:0] tcw_r;
	reg [7:0] blive_r;
	reg [7:0] binit_r;
	reg [15:0] bcnt_r;
	reg [23:0] area_base_r;
	reg done_r;
	reg [1:0] state_r;
	reg rx_dir_r;
	reg [23:0] restore;

	wire en;
	wire ie;
	wire sz;
	wire burst;
	wire [1:0] mode;
	wire [2:0] sel;
	wire hit;
	wire take;
	wire done_ev;
	wire [23:0] chptr_step;
	wire [23:0] src_step;
	wire [23:0] dst_step;
	wire [23:0] short_full;
	wire [23:0] init_scaled;
	wire [7:0] rlive_dec;
	wire [7:0] blive_dec;
	wire [15:0] tcw_dec;
	wire [15:0] bcnt_dec;
	wire block_end;

	assign en = ctrl_r[`DMARB_B_EN];
	assign ie = ctrl_r[`DMARB_B_DONE_IE];
	assign sz = ctrl_r[`DMARB_B_SIZE];
	assign burst = ctrl_r[`DMARB_B_BURST];
	assign mode = ctrl_r[`DMARB_F_MODE];
	assign sel = ctrl_r[`DMARB_F_SEL];

	////////////////////////////////////////////////////////////////
	// submodules

	dmarb_req_sel u_sel (
		.sys_clk(sys_clk),
		.rst(rst),
		.enable(en),
		.mode(mode),
		.sel(sel),
		.level_sense(ctrl_r[`DMARB_B_LEVEL]),
		.irq_in(irq_in),
		.ext_req_n(ext_req_n),
		.take(take),
		.hit(hit),
		.irq_ack(irq_ack),
		.irq_hide(irq_hide)
	);

	// repeat pointer always steps
	dmarb_addr_step #(.AW(24)) u_chstep (
		.ptr(chptr_r),
		.step_en(1'b1),
		.dec(ctrl_r[`DMARB_B_SRC_DEC]),
		.size(sz),
		.next_ptr(chptr_step)
	);

	// RQ10: independent pointer stepping
	dmarb_addr_step #(.AW(24)) u_srcstep (
		.ptr(src_r),
		.step_en(ctrl_r[`DMARB_B_SRC_STEP]),
		.dec(ctrl_r[`DMARB_B_SRC_DEC]),
		.size(sz),
		.next_ptr(src_step)
	);

	dmarb_addr_step #(.AW(24)) u_dststep (
		.ptr(dst_r),
		.step_en(ctrl_r[`DMARB_B_DST_STEP]),
		.dec(ctrl_r[`DMARB_B_DST_DEC]),
		.size(sz),
		.next_ptr(dst_step)
	);

	////////////////////////////////////////////////////////////////
	// sequencing

	// request taken in idle or block state
	assign take = (state_r == ST_IDLE || state_r == ST_BLOCK) && hit;
	assign xfer_req = state_r == ST_XFER;
	assign xfer_word = sz;

	// RQ7: fixed address upper bits ones
	assign short_full = {`DMARB_SHORT_HI, short_r};
	// RQ4: restore amount scaled by size
	assign init_scaled = sz ? {15'h0000, rinit_r, 1'b0} : {16'h0000, rinit_r};
	assign rlive_dec = rlive_r - 8'h01;
	assign blive_dec = blive_r - 8'h01;
	assign tcw_dec = tcw_r - 16'h0001;
	assign bcnt_dec = bcnt_r - 16'h0001;
	assign block_end = mode == `DMARB_MODE_BLOCK && blive_dec == 8'h00;

	// RQ14: block and auto-request burst keep bus
	assign bus_hold = state_r == ST_XFER && !hp_bus_req &&
		(mode == `DMARB_MODE_BLOCK ||
		(mode == `DMARB_MODE_NORMAL && burst && sel == `DMARB_SEL_AUTO));

	// RQ11: RQ17: completion event
	assign done_ev = state_r == ST_XFER && xfer_ack && (
		(mode == `DMARB_MODE_NORMAL && tcw_dec == 16'h0000) ||
		(block_end && bcnt_dec == 16'h0000));
	// RQ6: no interrupt in repeat mode
	assign done_irq = done_r && ie;

	// RQ4: direction sets restore sign
	always @*
	begin
		if (ctrl_r[`DMARB_B_SRC_DEC])
			restore = chptr_step + init_scaled;
		else
			restore = chptr_step - init_scaled;
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			rx_dir_r <= 1'b0;
			xfer_src <= `DMARB_RST_PTR;
			xfer_dst <= `DMARB_RST_PTR;
		end
		else
		begin
			case (state_r)
				ST_IDLE, ST_BLOCK:
				begin
					if (take)
					begin
						state_r <= ST_XFER;
						rx_dir_r <= sel == `DMARB_SEL_RXF;
						if (mode == `DMARB_MODE_REPEAT)
						begin
							// RQ2: direction from source
							if (sel == `DMARB_SEL_RXF)
							begin
								xfer_src <= short_full;
								xfer_dst <= chptr_r;
							end
							else
							begin
								xfer_src <= chptr_r;
								xfer_dst <= short_full;
							end
						end
						else
						begin
							xfer_src <= src_r;
							xfer_dst <= dst_r;
						end
					end
					else if (!en)
						state_r <= ST_IDLE;
				end
				ST_XFER:
				begin
					if (xfer_ack)
					begin
						// RQ15: block continues without request
						if (block_end || mode != `DMARB_MODE_BLOCK || !en)
							state_r <= ST_IDLE;
						else
						begin
							state_r <= ST_XFER;
							xfer_src <= src_step;
							xfer_dst <= dst_step;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// registers and counters

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_r <= `DMARB_RST_CTRL;
			ctrlb_r <= 1'b0;
			chptr_r <= `DMARB_RST_PTR;
			short_r <= `DMARB_RST_B8;
			rlive_r <= `DMARB_RST_B8;
			rinit_r <= `DMARB_RST_B8;
			src_r <= `DMARB_RST_PTR;
			dst_r <= `DMARB_RST_PTR;
			tcw_r <= `DMARB_RST_B16;
			blive_r <= `DMARB_RST_B8;
			binit_r <= `DMARB_RST_B8;
			bcnt_r <= `DMARB_RST_B16;
			area_base_r <= `DMARB_RST_PTR;
			done_r <= 1'b0;
		end
		else
		begin
			if (reg_wr)
			begin
				case (reg_addr)
					`DMARB_OFF_CTRL: ctrl_r <= reg_wdata[`DMARB_CTRL_W-1:0];
					`DMARB_OFF_CTRLB: ctrlb_r <= reg_wdata[`DMARB_B_AREA_SRC];
					`DMARB_OFF_CHPTR: chptr_r <= reg_wdata[23:0];
					`DMARB_OFF_SHORT: short_r <= reg_wdata[7:0];
					`DMARB_OFF_RLIVE: rlive_r <= reg_wdata[7:0];
					`DMARB_OFF_RINIT: rinit_r <= reg_wdata[7:0];
					`DMARB_OFF_SRC: src_r <= reg_wdata[23:0];
					`DMARB_OFF_DST: dst_r <= reg_wdata[23:0];
					`DMARB_OFF_TCW: tcw_r <= reg_wdata[15:0];
					`DMARB_OFF_BLIVE: blive_r <= reg_wdata[7:0];
					`DMARB_OFF_BINIT: binit_r <= reg_wdata[7:0];
					`DMARB_OFF_BCNT: bcnt_r <= reg_wdata[15:0];
					`DMARB_OFF_STAT: done_r <= 1'b0;
					default: ;
				endcase
			end
			// block area start captured at each block start
			if (take && mode == `DMARB_MODE_BLOCK && state_r == ST_IDLE)
				area_base_r <= ctrlb_r ? src_r : dst_r;
			if (state_r == ST_XFER && xfer_ack)
			begin
				case (mode)
					`DMARB_MODE_REPEAT:
					begin
						// RQ1: RQ3: RQ8: count and reload
						if (rlive_dec == 8'h00)
						begin
							rlive_r <= rinit_r;
							chptr_r <= restore;
						end
						else
						begin
							rlive_r <= rlive_dec;
							chptr_r <= chptr_step;
						end
					end
					`DMARB_MODE_NORMAL:
					begin
						// RQ12: zero wraps to full range
						src_r <= src_step;
						dst_r <= dst_step;
						tcw_r <= tcw_dec;
						if (tcw_dec == 16'h0000)
							ctrl_r[`DMARB_B_EN] <= 1'b0;
					end
					`DMARB_MODE_BLOCK:
					begin
						// RQ16: RQ18: RQ21: block end handling
						if (block_end)
						begin
							blive_r <= binit_r;
							bcnt_r <= bcnt_dec;
							src_r <= ctrlb_r ? area_base_r : src_step;
							dst_r <= ctrlb_r ? dst_step : area_base_r;
							if (bcnt_dec == 16'h0000)
								ctrl_r[`DMARB_B_EN] <= 1'b0;
						end
						else
						begin
							blive_r <= blive_dec;
							src_r <= src_step;
							dst_r <= dst_step;
						end
					end
					default: ;
				endcase
			end
			// set wins over clear
			if (done_ev)
				done_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// read port

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`DMARB_OFF_CTRL: reg_rdata <= {17'h00000, ctrl_r};
				`DMARB_OFF_CTRLB: reg_rdata <= {31'h00000000, ctrlb_r};
				`DMARB_OFF_CHPTR: reg_rdata <= {8'h00, chptr_r};
				`DMARB_OFF_SHORT: reg_rdata <= {24'h000000, short_r};
				`DMARB_OFF_RLIVE: reg_rdata <= {24'h000000, rlive_r};
				`DMARB_OFF_RINIT: reg_rdata <= {24'h000000, rinit_r};
				`DMARB_OFF_SRC: reg_rdata <= {8'h00, src_r};
				`DMARB_OFF_DST: reg_rdata <= {8'h00, dst_r};
				`DMARB_OFF_TCW: reg_rdata <= {16'h0000, tcw_r};
				`DMARB_OFF_BLIVE: reg_rdata <= {24'h000000, blive_r};
				`DMARB_OFF_BINIT: reg_rdata <= {24'h000000, binit_r};
				`DMARB_OFF_BCNT: reg_rdata <= {16'h0000, bcnt_r};
				`DMARB_OFF_STAT: reg_rdata <= {28'h0000000, rx_dir_r, state_r, done_r};
				default: reg_rdata <= 32'h00000000;
			endcase
		end
		else
			reg_rdata <= 32'h00000000;
	end
endmodule

// ### dmarb_top_props.sv
`timescale 1ns/10ps
module dmarb_top_props (
	input wire sys_clk,
	input wire rst,
	input wire reg_wr,
	input wire [5:0] irq_in,
	input wire [5:0] irq_ack,
	input wire [5:0] irq_hide,
	input wire hp_bus_req,
	input wire xfer_req,
	input wire [23:0] xfer_src,
	input wire [23:0] xfer_dst,
	input wire xfer_ack,
	input wire bus_hold,
	input wire done_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_take;
		irq_ack != 6'h00;
	endsequence
	sequence s_wait;
		xfer_req && !xfer_ack;
	endsequence
	a_ack_flag_set: assert property (s_take |-> (irq_ack & ~irq_in) == 6'h00)
		else $error("ack without flag");
	a_ack_hidden: assert property (s_take |-> (irq_ack & ~irq_hide) == 6'h00)
		else $error("taken flag not hidden");
	a_ack_single: assert property ($onehot0(irq_ack))
		else $error("several flags taken");
	a_take_starts: assert property (s_take |=> xfer_req)
		else $error("take without transfer");
	a_req_holds: assert property (s_wait |=> xfer_req && $stable(xfer_src) && $stable(xfer_dst))
		else $error("transfer changed before ack");
	a_hp_release: assert property (hp_bus_req |-> !bus_hold)
		else $error("bus held against request");
	a_done_cause: assert property ($rose(done_irq) |-> $past(xfer_ack) || $past(reg_wr))
		else $error("done without completion");
	a_done_clear: assert property ($fell(done_irq) |-> $past(reg_wr))
		else $error("done dropped alone");
endmodule

// ### dmarb_bus_model.sv
`timescale 1ns/10ps
module dmarb_bus_model (
	input wire sys_clk,
	input wire rst,
	input wire xfer_req,
	input wire [5:0] irq_ack,
	input wire [5:0] raise,
	input wire slow,
	output logic xfer_ack,
	output logic [5:0] irq_in
);
	logic [1:0] wait_r;
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			xfer_ack <= 1'b0;
			wait_r <= 2'h0;
			irq_in <= 6'h00;
		end
		else
		begin
			// flag stands until the channel takes it
			irq_in <= (irq_in & ~irq_ack) | raise;
			xfer_ack <= xfer_req && !xfer_ack && (wait_r == {slow, slow});
			wait_r <= (xfer_req && !xfer_ack && wait_r != {slow, slow}) ? wait_r + 2'h1 : 2'h0;
		end
	end
endmodule

// ### test_dmarb_top.sv
`timescale 1ns/10ps
`include "dmarb_defines.vh"
module test_dmarb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ext_req_n = 1'b1;
	logic hp_bus_req = 1'b0;
	logic slow = 1'b0;
	logic [5:0] raise = 6'h00;
	wire [31:0] reg_rdata;
	wire [5:0] irq_in, irq_ack, irq_hide;
	wire xfer_req, xfer_word, xfer_ack, bus_hold, done_irq;
	wire [23:0] xfer_src, xfer_dst;
	logic [23:0] qs[$];
	logic [23:0] qd[$];
	logic qh[$];
	int err_count = 0;
	int checked = 0;
	initial forever #50 sys_clk = ~sys_clk;
	dmarb_top dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_in(irq_in), .ext_req_n(ext_req_n),
		.irq_ack(irq_ack), .irq_hide(irq_hide), .hp_bus_req(hp_bus_req), .xfer_req(xfer_req),
		.xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_word(xfer_word), .xfer_ack(xfer_ack),
		.bus_hold(bus_hold), .done_irq(done_irq));
	dmarb_bus_model bus_u (.sys_clk(sys_clk), .rst(rst), .xfer_req(xfer_req), .irq_ack(irq_ack),
		.raise(raise), .slow(slow), .xfer_ack(xfer_ack), .irq_in(irq_in));
	always @(negedge sys_clk)
		if (xfer_req && xfer_ack)
		begin
			qs.push_back(xfer_src);
			qd.push_back(xfer_dst);
			qh.push_back(bus_hold);
		end
	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		cmp(reg_rdata, exp);
		@(posedge sys_clk);
	endtask
	task automatic flag(input logic [5:0] b);
		raise <= b;
		@(posedge sys_clk);
		raise <= 6'h00;
		@(posedge sys_clk);
	endtask
	task automatic ext_edge;
		ext_req_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		ext_req_n <= 1'b1;
		@(posedge sys_clk);
	endtask
	task automatic wait_q(input int n);
		int i;
		for (i = 0; i < 100 && qs.size() < n; i++)
			@(posedge sys_clk);
		if (qs.size() < n)
		begin
			err_count++;
			$display("Error %0t: transfer timeout", $time);
			complete_run();
		end
	endtask
	task automatic xf(input int i, input logic [23:0] s, input logic [23:0] d);
		cmp({8'h00, qs[i]}, {8'h00, s});
		cmp({8'h00, qd[i]}, {8'h00, d});
	endtask
	task automatic idle_count(input int n);
		repeat (10) @(posedge sys_clk);
		cmp(32'(qs.size()), 32'(n));
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_repeat;
		rd(`DMARB_OFF_CTRL, 32'h0);
		rd(8'hFC, 32'h0);
		wr(`DMARB_OFF_RLIVE, 32'h2);
		wr(`DMARB_OFF_RINIT, 32'h2);
		wr(`DMARB_OFF_CHPTR, 32'h100);
		wr(`DMARB_OFF_SHORT, 32'h40);
		rd(`DMARB_OFF_SHORT, 32'h40);
		wr(`DMARB_OFF_CTRL, 32'h7);
		cmp({26'h0, irq_hide}, 32'h1);
		cmp({31'h0, xfer_word}, 32'h1);
		for (int k = 1; k < 4; k++)
		begin
			flag(6'h01);
			wait_q(k);
		end
		xf(0, 24'h000100, 24'hFFFF40);
		xf(1, 24'h000102, 24'hFFFF40);
		xf(2, 24'h000100, 24'hFFFF40);
		rd(`DMARB_OFF_RLIVE, 32'h1);
		rd(`DMARB_OFF_RINIT, 32'h2);
		wr(`DMARB_OFF_CTRL, 32'h6);
		flag(6'h01);
		idle_count(3);
		cmp({31'h0, done_irq}, 32'h0);
		wr(`DMARB_OFF_CTRL, 32'h7);
		wait_q(4);
		xf(3, 24'h000102, 24'hFFFF40);
		wr(`DMARB_OFF_CTRL, 32'h4007);
		flag(6'h10);
		wait_q(5);
		xf(4, 24'hFFFF40, 24'h000100);
		wr(`DMARB_OFF_CTRL, 32'h0);
	endtask
	task automatic t_normal;
		hp_bus_req <= 1'b1;
		slow <= 1'b1;
		wr(`DMARB_OFF_SRC, 32'h1000);
		wr(`DMARB_OFF_DST, 32'h2000);
		wr(`DMARB_OFF_TCW, 32'h3);
		wr(`DMARB_OFF_CTRL, 32'h72F3);
		wait_q(6);
		cmp({31'h0, xfer_word}, 32'h0);
		hp_bus_req <= 1'b0;
		wait_q(8);
		@(posedge sys_clk);
		cmp({31'h0, qh[5]}, 32'h0);
		cmp({31'h0, qh[6]}, 32'h1);
		xf(5, 24'h001000, 24'h002000);
		xf(6, 24'h001001, 24'h001FFF);
		xf(7, 24'h001002, 24'h001FFE);
		cmp({31'h0, done_irq}, 32'h1);
		rd(`DMARB_OFF_CTRL, 32'h72F2);
		rd(`DMARB_OFF_STAT, 32'h1);
		idle_count(8);
		wr(`DMARB_OFF_STAT, 32'h0);
		cmp({31'h0, done_irq}, 32'h0);
		slow <= 1'b0;
		wr(`DMARB_OFF_SRC, 32'h5000);
		wr(`DMARB_OFF_DST, 32'h6000);
		wr(`DMARB_OFF_TCW, 32'h0);
		wr(`DMARB_OFF_CTRL, 32'h6201);
		ext_edge();
		wait_q(9);
		ext_edge();
		wait_q(10);
		xf(9, 24'h005000, 24'h006000);
		cmp({31'h0, qh[9]}, 32'h0);
		rd(`DMARB_OFF_TCW, 32'hFFFE);
		rd(`DMARB_OFF_CTRL, 32'h6201);
		wr(`DMARB_OFF_CTRL, 32'h0);
	endtask
	task automatic t_block;
		wr(`DMARB_OFF_CTRLB, 32'h0);
		wr(`DMARB_OFF_BLIVE, 32'h2);
		wr(`DMARB_OFF_BINIT, 32'h2);
		wr(`DMARB_OFF_BCNT, 32'h2);
		wr(`DMARB_OFF_SRC, 32'h3000);
		wr(`DMARB_OFF_DST, 32'h4000);
		wr(`DMARB_OFF_CTRL, 32'h3453);
		flag(6'h08);
		idle_count(10);
		cmp({31'h0, irq_in[3]}, 32'h1);
		cmp({26'h0, irq_hide}, 32'h0);
		wr(`DMARB_OFF_CTRL, 32'h6453);
		ext_edge();
		wait_q(12);
		idle_count(12);
		ext_edge();
		wait_q(14);
		@(posedge sys_clk);
		xf(10, 24'h003000, 24'h004000);
		xf(11, 24'h003001, 24'h004001);
		xf(12, 24'h003002, 24'h004000);
		xf(13, 24'h003003, 24'h004001);
		cmp({31'h0, done_irq}, 32'h1);
		rd(`DMARB_OFF_CTRL, 32'h6452);
		rd(`DMARB_OFF_BLIVE, 32'h2);
		rd(`DMARB_OFF_BCNT, 32'h0);
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_repeat();
		t_normal();
		t_block();
		complete_run();
	end
endmodule
bind dmarb_top dmarb_top_props props_u (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .irq_in(irq_in),
	.irq_ack(irq_ack), .irq_hide(irq_hide), .hp_bus_req(hp_bus_req), .xfer_req(xfer_req),
	.xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_ack(xfer_ack), .bus_hold(bus_hold), .done_irq(done_irq));
